// File: rdric_top.sv
// Purpose: Interrupt controller of a contactless reader frontend.
// Assumes: Event sources on clk_i; APB slave with one wait state.
// Notes:   Bit 7 of flag and enable writes picks set or clear.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "rdric_regs.svh"

module rdric_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire rdric_pkg::rdric_src_t src_i,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    function automatic logic [31:0] pad8(input logic [7:0] v);
        pad8 = {24'h000000, v};
    endfunction : pad8

    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction : rise

    // ------------------------------------------------------------------
    // APB request
    // ------------------------------------------------------------------
    rdric_pkg::rdric_apb_req_t req;

    assign req.psel = psel_i;
    assign req.penable = penable_i;
    assign req.pwrite = pwrite_i;
    assign req.paddr = paddr_i;
    assign req.pwdata = pwdata_i;

    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    wire access = req.psel & req.penable;
    wire fire = access & pready_q;
    wire wr_fire = fire & req.pwrite;

    wire hit_f0 = addr_is(req.paddr, `RDRIC_OFF_FLAGS0);
    wire hit_f1 = addr_is(req.paddr, `RDRIC_OFF_FLAGS1);
    wire hit_e0 = addr_is(req.paddr, `RDRIC_OFF_EN0);
    wire hit_e1 = addr_is(req.paddr, `RDRIC_OFF_EN1);
    wire hit_st = addr_is(req.paddr, `RDRIC_OFF_STATUS);
    wire hit_wm = addr_is(req.paddr, `RDRIC_OFF_WMARK);
    wire mapped = hit_f0 | hit_f1 | hit_e0 | hit_e1 | hit_st | hit_wm;

    wire wr_f0 = wr_fire & hit_f0;
    wire wr_f1 = wr_fire & hit_f1;
    wire wr_e0 = wr_fire & hit_e0;
    wire wr_e1 = wr_fire & hit_e1;
    wire wr_wm = wr_fire & hit_wm;
    wire [7:0] wbyte = req.pwdata[7:0];

    // ------------------------------------------------------------------
    // Source conditioning
    // ------------------------------------------------------------------
    logic tx_data_q;
    logic cmd_busy_q;
    logic hi_q;
    logic lo_q;
    logic [8:0] wmark_q;
    logic [8:0] wmark_d;

    wire [9:0] fifo_free = `RDRIC_FIFO_SIZE - src_i.fifo_level;
    wire [9:0] wm_high = {1'b0, wmark_q};
    wire [9:0] wm_low = {2'b00, wmark_q[7:0]};
    wire hi_now = (fifo_free <= wm_high);
    wire lo_now = (src_i.fifo_level <= wm_low);
    wire cmd_idle_now = (src_i.cmd_code == `RDRIC_CMD_IDLE);

    wire ev_tx = tx_data_q & src_i.tx_sending_eof;
    wire ev_rx = src_i.rx_end;
    wire ev_idle = rise(cmd_idle_now, ~cmd_busy_q);
    wire ev_hi = rise(hi_now, hi_q);
    wire ev_lo = rise(lo_now, lo_q);
    wire ev_err = |src_i.rx_error;
    wire ev_card = src_i.card_detect;
    wire ev_sof = src_i.sof_detect;
    wire [3:0] ev_tmr = src_i.timer_underflow;

    assign wmark_d = wr_wm ? req.pwdata[`RDRIC_WM_EXT:0] : wmark_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_data_q <= 1'b0;
            cmd_busy_q <= 1'b0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            wmark_q <= `RDRIC_RST_WMARK;
        end else begin
            tx_data_q <= src_i.tx_sending_data;
            cmd_busy_q <= ~cmd_idle_now;
            hi_q <= hi_now;
            lo_q <= lo_now;
            wmark_q <= wmark_d;
        end
    end

    // ------------------------------------------------------------------
    // Flag and enable registers
    // ------------------------------------------------------------------
    logic [6:0] flags0;
    logic [6:0] flags1;
    logic [6:0] en0;
    logic [6:0] en1;
    logic [6:0] set0;
    logic [6:0] set1;

    assign set0[`RDRIC_F0_TX] = ev_tx;
    assign set0[`RDRIC_F0_RX] = ev_rx;
    assign set0[`RDRIC_F0_IDLE] = ev_idle;
    assign set0[`RDRIC_F0_HI] = ev_hi;
    assign set0[`RDRIC_F0_LO] = ev_lo;
    assign set0[`RDRIC_F0_ERR] = ev_err;
    assign set0[`RDRIC_F0_CARD] = ev_card;

    wire [6:0] pend0 = flags0 & en0;
    wire [6:0] pend1 = flags1 & en1 & `RDRIC_SRC_EN1;
    wire any_pend = (|pend0) | (|pend1);

    assign set1[`RDRIC_F1_TMR_LSB +: 4] = ev_tmr;
    assign set1[`RDRIC_F1_SOF] = ev_sof;
    assign set1[`RDRIC_F1_ANY] = any_pend;
    assign set1[`RDRIC_E1_PIN] = 1'b0;

    rdric_setclr u_flags0 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_f0),
        .wdata_i(wbyte),
        .wmask_i(`RDRIC_MASK_FULL),
        .set_i(set0),
        .q_o(flags0)
    );

    rdric_setclr u_flags1 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_f1),
        .wdata_i(wbyte),
        .wmask_i(`RDRIC_MASK_FLAGS1),
        .set_i(set1),
        .q_o(flags1)
    );

    rdric_setclr u_en0 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_e0),
        .wdata_i(wbyte),
        .wmask_i(`RDRIC_MASK_FULL),
        .set_i(`RDRIC_RST_FLAGS),
        .q_o(en0)
    );

    rdric_setclr u_en1 (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_e1),
        .wdata_i(wbyte),
        .wmask_i(`RDRIC_MASK_FULL),
        .set_i(`RDRIC_RST_FLAGS),
        .q_o(en1)
    );

    // ------------------------------------------------------------------
    // Status and interrupt pin
    // ------------------------------------------------------------------
    logic irq_st_q;
    logic irq_q;
    wire pin_en = en1[`RDRIC_E1_PIN];
    wire [7:0] status_byte = {5'h00, hi_q, lo_q, irq_st_q} & 8'h07;
    wire [7:0] status_rd;

    assign status_rd[`RDRIC_ST_IRQ] = irq_st_q;
    assign status_rd[`RDRIC_ST_HI] = status_byte[`RDRIC_ST_LO];
    assign status_rd[`RDRIC_ST_LO] = status_byte[`RDRIC_ST_HI];
    assign status_rd[7:3] = 5'h00;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_st_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= any_pend;
            irq_q <= any_pend & pin_en;
        end
    end

    // ------------------------------------------------------------------
    // APB read path and answer
    // ------------------------------------------------------------------
    wire [31:0] rd_f0 = hit_f0 ? pad8({1'b0, flags0}) : `RDRIC_ZERO32;
    wire [31:0] rd_f1 = hit_f1 ? pad8({1'b0, flags1}) : `RDRIC_ZERO32;
    wire [31:0] rd_e0 = hit_e0 ? pad8({1'b0, en0}) : `RDRIC_ZERO32;
    wire [31:0] rd_e1 = hit_e1 ? pad8({1'b0, en1}) : `RDRIC_ZERO32;
    wire [31:0] rd_st = hit_st ? pad8(status_rd) : `RDRIC_ZERO32;
    wire [31:0] rd_wm = hit_wm ? {23'h0, wmark_q} : `RDRIC_ZERO32;
    wire [31:0] rd_mux = rd_f0 | rd_f1 | rd_e0 | rd_e1 | rd_st | rd_wm;

    // One wait state: answer on the second access cycle
    assign pready_d = access & ~pready_q;
    assign pslverr_d = pready_d & ~mapped;
    assign prdata_d = (pready_d & ~req.pwrite) ? rd_mux : `RDRIC_ZERO32;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `RDRIC_ZERO32;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;
    assign irq_o = irq_q;

endmodule : rdric_top

// File: rdric_regs.svh
// Purpose: Register offsets, bit positions and reset values of the reader
//          interrupt controller.
// Assumes: Byte addresses on an 8-bit APB address.
// Notes:   Definitions only.
`ifndef RDRIC_REGS_SVH
`define RDRIC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RDRIC_OFF_FLAGS0 8'h00
`define RDRIC_OFF_FLAGS1 8'h04
`define RDRIC_OFF_EN0 8'h08
`define RDRIC_OFF_EN1 8'h0c
`define RDRIC_OFF_STATUS 8'h10
`define RDRIC_OFF_WMARK 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RDRIC_SEL_BIT 7
`define RDRIC_F0_TX 0
`define RDRIC_F0_RX 1
`define RDRIC_F0_IDLE 2
`define RDRIC_F0_HI 3
`define RDRIC_F0_LO 4
`define RDRIC_F0_ERR 5
`define RDRIC_F0_CARD 6
`define RDRIC_F1_TMR_LSB 0
`define RDRIC_F1_SOF 4
`define RDRIC_F1_ANY 5
`define RDRIC_E1_PIN 6
`define RDRIC_ST_IRQ 0
`define RDRIC_ST_HI 1
`define RDRIC_ST_LO 2
`define RDRIC_WM_EXT 8

// ----------------------------------------------------------------------
// Masks, reset values and constants
// ----------------------------------------------------------------------
`define RDRIC_MASK_FULL 7'h7f
`define RDRIC_MASK_FLAGS1 7'h3f
`define RDRIC_SRC_EN1 7'h1f
`define RDRIC_RST_FLAGS 7'h00
`define RDRIC_RST_WMARK 9'h000
`define RDRIC_CMD_IDLE 5'h00
`define RDRIC_FIFO_SIZE 10'h200
`define RDRIC_ZERO32 32'h00000000

`endif

// File: rdric_pkg.sv
// Purpose: Types shared by the reader interrupt controller files.
// Assumes: Source signals come from logic on the same clock.
// Notes:   Constants live in rdric_regs.svh.
package rdric_pkg;

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] timer_underflow;
        logic tx_sending_data;
        logic tx_sending_eof;
        logic rx_end;
        logic [4:0] cmd_code;
        logic [7:0] rx_error;
        logic card_detect;
        logic sof_detect;
        logic [9:0] fifo_level;
    } rdric_src_t;

    // ------------------------------------------------------------------
    // APB request as seen by the slave
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rdric_apb_req_t;

endpackage : rdric_pkg

// File: rdric_setclr.sv
// Purpose: Seven-bit register with a set-or-clear selector in bit 7.
// Assumes: wr_i is a one-cycle write strobe.
// Notes:   Hardware set wins over a software clear in the same cycle.
`timescale 1ns/1ns
`include "rdric_regs.svh"

module rdric_setclr (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [6:0] wmask_i,
    input wire logic [6:0] set_i,
    output logic [6:0] q_o
);

    logic [6:0] q_q;
    logic [6:0] q_d;
    wire [6:0] hit = wdata_i[6:0] & wmask_i;
    wire sel = wdata_i[`RDRIC_SEL_BIT];
    wire [6:0] sw_set = q_q | hit;
    wire [6:0] sw_clr = q_q & ~hit;
    wire [6:0] sw_val = sel ? sw_set : sw_clr;
    wire [6:0] base = wr_i ? sw_val : q_q;

    // Event set has priority over a clear in the same cycle
    assign q_d = base | (set_i & wmask_i);
    assign q_o = q_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_q <= `RDRIC_RST_FLAGS;
        end else begin
            q_q <= q_d;
        end
    end

endmodule : rdric_setclr

// File: rdric_top_asserts.sv
// Purpose: Port-level checks of the reader interrupt controller.
// Assumes: Master holds each APB request until pready_o.
// Notes:   Bound into rdric_top below.
`timescale 1ns/1ns
module rdric_top_asserts (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_answer;
        !pready_o ##1 pready_o;
    endsequence
    sequence s_rd_status;
        pready_o && !pwrite_i && paddr_i == 8'h10;
    endsequence

    property p_wait;
        s_setup |=> s_answer;
    endproperty
    property p_pulse;
        pready_o |=> !pready_o;
    endproperty
    property p_err_map;
        pready_o |-> pslverr_o == (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0);
    endproperty
    property p_err_ready;
        pslverr_o |-> pready_o && psel_i && penable_i;
    endproperty
    property p_idle_zero;
        !pready_o |-> prdata_o == 32'h0;
    endproperty
    property p_top_zero;
        pready_o |-> prdata_o[31:9] == 23'h0 &&
            (paddr_i == 8'h14 || prdata_o[8:7] == 2'h0);
    endproperty
    property p_rsvd;
        pready_o && paddr_i == 8'h04 |-> !prdata_o[6];
    endproperty
    property p_hold;
        irq_o && !psel_i && !$past(psel_i) |=> irq_o;
    endproperty
    property p_status;
        s_rd_status and (irq_o && $past(irq_o, 2)) |-> prdata_o[0];
    endproperty

    a_wait: assert property (p_wait) else $error("no wait");
    a_pulse: assert property (p_pulse) else $error("long ready");
    a_err_map: assert property (p_err_map) else $error("wrong err");
    a_err_ready: assert property (p_err_ready) else $error("bad err");
    a_idle_zero: assert property (p_idle_zero) else $error("nonzero");
    a_top_zero: assert property (p_top_zero) else $error("bit7 set");
    a_rsvd: assert property (p_rsvd) else $error("bit6 set");
    a_hold: assert property (p_hold) else $error("irq dropped");
    a_status: assert property (p_status) else $error("status low");
endmodule : rdric_top_asserts

bind rdric_top rdric_top_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o));

// File: rdric_host_model.sv
// Purpose: Host side: APB master that reaches the interrupt registers.
// Assumes: xfer is called just after a rising edge.
// Notes:   Request held until pready_i is seen high.
`timescale 1ns/1ns
module rdric_host_model (
    input wire logic clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
    end

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : rdric_host_model

// File: rdric_top_tb_top.sv
// Purpose: Self-checking bench of the reader interrupt controller.
// Assumes: Host model makes all APB transfers.
// Notes:   Events are driven on the source struct.
`timescale 1ns/1ns
module rdric_top_tb_top;
    logic clk_i, arst_n_i, psel, pen, pwr, rdy, err, irq;
    logic [7:0] addr;
    logic [31:0] wdat, rdat;
    rdric_pkg::rdric_src_t src;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;

    rdric_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat),
        .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err), .src_i(src),
        .irq_o(irq));
    rdric_host_model u_host (.clk_i(clk_i), .prdata_i(rdat), .pready_i(rdy),
        .pslverr_i(err), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
        .paddr_o(addr), .pwdata_o(wdat));

    task give_verdict;
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Quiet sources: FIFO half full, no event, idle command
    function automatic rdric_pkg::rdric_src_t at_rest();
        at_rest = '0;
        at_rest.fifo_level = 10'h100;
    endfunction : at_rest

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, a, d, r, e);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd

    // ------------------------------------------------------------------
    // Event k raised on the sources, then all returned to rest
    // ------------------------------------------------------------------
    task fire(input int k);
        case (k)
            0: begin
                src.tx_sending_data <= 1'b1;
                @(posedge clk_i);
                src.tx_sending_data <= 1'b0;
                src.tx_sending_eof <= 1'b1;
            end
            1: src.rx_end <= 1'b1;
            2: src.cmd_code <= 5'h03;
            3: src.fifo_level <= 10'h1f8;
            4: src.fifo_level <= 10'h008;
            5: src.rx_error <= 8'h04;
            6: src.card_detect <= 1'b1;
            11: src.sof_detect <= 1'b1;
            default: src.timer_underflow <= 4'h1 << (k - 7);
        endcase
        @(posedge clk_i);
        src <= at_rest();
    endtask : fire

    task t_reset;
        for (int a = 0; a < 24; a += 4) begin
            rd(8'(a), 32'h0);
        end
    endtask : t_reset

    task t_setclr;
        wr(8'h08, 32'hff);
        rd(8'h08, 32'h7f);
        wr(8'h08, 32'h05);
        rd(8'h08, 32'h7a);
        wr(8'h08, 32'h00);
        rd(8'h08, 32'h7a);
        wr(8'h04, 32'h9f);
        rd(8'h04, 32'h1f);
        wr(8'h04, 32'h1f);
        rd(8'h04, 32'h0);
    endtask : t_setclr

    task t_events;
        wr(8'h14, 32'h10);
        wr(8'h08, 32'hff);
        wr(8'h0c, 32'hdf);
        rd(8'h0c, 32'h5f);
        for (int k = 0; k < 12; k++) begin
            fire(k);
            rd(8'h00, k < 7 ? 32'h1 << k : 32'h0);
            rd(8'h04, 32'h20 | (k > 6 ? 32'h1 << (k - 7) : 32'h0));
            rd(8'h10, 32'h1);
            chk({31'h0, irq}, 32'h1);
            wr(8'h00, 32'h7f);
            wr(8'h04, 32'h1f);
            wr(8'h04, 32'h20);
            rd(8'h04, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
    endtask : t_events

    task t_mask;
        wr(8'h0c, 32'h7f);
        wr(8'h08, 32'h7f);
        fire(7);
        rd(8'h04, 32'h1);
        rd(8'h10, 32'h0);
        wr(8'h0c, 32'h81);
        rd(8'h10, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(8'h0c, 32'hc0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
    endtask : t_mask

    task t_bus;
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, 8'h18, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        wr(8'h10, 32'hff);
        rd(8'h10, 32'h1);
        wr(8'h14, 32'h105);
        rd(8'h14, 32'h105);
        rd(8'h10, 32'h3);
        rd(8'h00, 32'h8);
    endtask : t_bus

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict;
        end
    end

    initial begin
        src = at_rest();
        arst_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset;
        t_setclr;
        t_events;
        t_mask;
        t_bus;
        give_verdict;
    end
endmodule : rdric_top_tb_top
